// >>> sld_alu.sv
// Purpose: Package and combinational result unit of the shift, logic and bit datapath.
// Assumes: Operands are already selected by the caller; nothing here is clocked.
// Notes:   The caller decides where the result goes and which flags it may keep.

// ----------------------------------------------------------------------------
// Shared constants
// ----------------------------------------------------------------------------
package sld_pkg;
  localparam logic [7:0] SLD_OFF_WREG  = 8'h00;
  localparam logic [7:0] SLD_OFF_FLAGS = 8'h04;
  localparam logic [7:0] SLD_OFF_CMD   = 8'h08;
  localparam logic [7:0] SLD_OFF_MEM   = 8'h40;
  localparam logic [7:0] SLD_OFF_IO    = 8'h80;
  localparam int         SLD_MEM_WORDS = 16;
  localparam int         SLD_IO_REGS   = 4;
  localparam int         SLD_CMD_OP    = 0;
  localparam int         SLD_CMD_DSTM  = 4;
  localparam int         SLD_CMD_SRCM  = 5;
  localparam int         SLD_CMD_IO    = 6;
  localparam int         SLD_CMD_BIT   = 8;
  localparam int         SLD_CMD_ADDR  = 12;
  localparam int         SLD_CMD_IMM   = 16;
  localparam int         SLD_FLG_Z     = 0;
  localparam int         SLD_FLG_C     = 1;
  localparam int         SLD_FLG_HALF  = 2;
  localparam int         SLD_FLG_SRNG  = 3;
  localparam logic [7:0] SLD_WREG_RST  = 8'h00;
  localparam logic [3:0] SLD_FLAGS_RST = 4'h0;
  localparam logic [7:0] SLD_BYTE_RST  = 8'h00;

  typedef enum logic [3:0] {
    SLD_OP_SRZ  = 4'h0,
    SLD_OP_RRC  = 4'h1,
    SLD_OP_SLZ  = 4'h2,
    SLD_OP_RLC  = 4'h3,
    SLD_OP_SWAP = 4'h4,
    SLD_OP_AND  = 4'h5,
    SLD_OP_OR   = 4'h6,
    SLD_OP_XOR  = 4'h7,
    SLD_OP_NOT  = 4'h8,
    SLD_OP_NEG  = 4'h9,
    SLD_OP_BCLR = 4'ha,
    SLD_OP_BSET = 4'hb
  } sld_op_t;
endpackage

`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Result unit
// ----------------------------------------------------------------------------
module sld_alu
  import sld_pkg::*;
(
  input  wire logic [3:0] op,
  input  wire logic [7:0] wreg,
  input  wire logic [7:0] src,
  input  wire logic [7:0] tgt,
  input  wire logic       cin,
  input  wire logic [2:0] bitn,
  output logic      [7:0] res,
  output logic            cout,
  output logic            upd_z,
  output logic            upd_c,
  output logic            legal
);

  always_comb begin
    res   = tgt;
    cout  = cin;
    upd_z = 1'b0;
    upd_c = 1'b0;
    legal = 1'b1;
    case (op)
      SLD_OP_SRZ: begin
        res   = {1'b0, tgt[7:1]};
        cout  = tgt[0];
        upd_c = 1'b1;
      end
      SLD_OP_RRC: begin
        res   = {cin, tgt[7:1]};
        cout  = tgt[0];
        upd_c = 1'b1;
      end
      SLD_OP_SLZ: begin
        res   = {tgt[6:0], 1'b0};
        cout  = tgt[7];
        upd_c = 1'b1;
      end
      SLD_OP_RLC: begin
        res   = {tgt[6:0], cin};
        cout  = tgt[7];
        upd_c = 1'b1;
      end
      SLD_OP_SWAP: res = {tgt[3:0], tgt[7:4]};
      SLD_OP_AND: begin
        res   = wreg & src;
        upd_z = 1'b1;
      end
      SLD_OP_OR: begin
        res   = wreg | src;
        upd_z = 1'b1;
      end
      SLD_OP_XOR: begin
        res   = wreg ^ src;
        upd_z = 1'b1;
      end
      SLD_OP_NOT: begin
        res   = ~tgt;
        upd_z = 1'b1;
      end
      SLD_OP_NEG: begin
        res   = 8'(~tgt + 8'h01);
        upd_z = 1'b1;
      end
      SLD_OP_BCLR: res[bitn] = 1'b0;
      SLD_OP_BSET: res[bitn] = 1'b1;
      default:     legal = 1'b0;
    endcase
  end

endmodule // sld_alu

// >>> sld_datapath.sv
// Purpose: APB-reached shift, rotate, swap, logic, complement and bit datapath of an 8-bit core.
// Assumes: Single clock; software stands in for the instruction decoder through the command register.
// Notes:   A command executes at the APB write edge; results are visible to the very next read.
//
// Notes on behaviour
// - Shift right of working register fills bit 7 with zero; bit 0 to borrow.
// - Rotate right through borrow: old borrow into bit 7, bit 0 out.
// - Shift left fills bit 0 with zero; old bit 7 goes to borrow.
// - Rotate left through borrow: old borrow into bit 0, bit 7 out.
// - All four shifts also work in place on a memory byte.
// - Nibble swap of working register changes no flag.
// - AND with immediate or memory byte; only zero flag changes.
// - OR with immediate or memory byte; only zero flag changes.
// - XOR with immediate or memory byte; only zero flag changes.
// - XOR of working register into I/O register changes no flag.
// - One's complement in place of working register or memory; zero flag only.
// - Two's complement in place of working register or memory; zero flag only.
// - Bit clear on I/O register forces bit n low, no flag change.
// - Bit set on I/O register forces bit n high, no flag change.
// - Bit clear and set also work on memory bytes, no flag change.
//
// Added by the designer: the address map and the APB interface to the registers.

`timescale 1ns/100ps

module sld_datapath
  import sld_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  working_register,
  output logic      [31:0] io_port
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base, input int words);
    return (a >= base) && (a < 8'(int'(base) + words * 4));
  endfunction

  function automatic logic [3:0] word_index(input logic [7:0] a, input logic [7:0] base);
    return 4'((a - base) >> 2);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]  wreg_q;
  logic [3:0]  flags_q;
  logic [7:0]  mem_q [SLD_MEM_WORDS];
  logic [7:0]  io_q  [SLD_IO_REGS];
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic [3:0]  cmd_op;
  logic        cmd_dstm;
  logic        cmd_srcm;
  logic        cmd_io;
  logic [2:0]  cmd_bit;
  logic [3:0]  cmd_addr;
  logic [7:0]  cmd_imm;
  logic [7:0]  mem_byte;
  logic [7:0]  io_byte;
  logic [7:0]  src_byte;
  logic [7:0]  tgt_byte;
  logic [7:0]  alu_res;
  logic        alu_cout;
  logic        alu_upd_z;
  logic        alu_upd_c;
  logic        alu_legal;
  logic        cmd_legal;
  logic        bus_err;
  logic        acc_done;
  logic        op_go;
  logic        to_mem;
  logic        to_io;

  assign cmd_op   = pwdata[SLD_CMD_OP +: 4];
  assign cmd_dstm = pwdata[SLD_CMD_DSTM];
  assign cmd_srcm = pwdata[SLD_CMD_SRCM];
  assign cmd_io   = pwdata[SLD_CMD_IO];
  assign cmd_bit  = pwdata[SLD_CMD_BIT +: 3];
  assign cmd_addr = pwdata[SLD_CMD_ADDR +: 4];
  assign cmd_imm  = pwdata[SLD_CMD_IMM +: 8];
  assign mem_byte = mem_q[cmd_addr];
  assign io_byte  = io_q[cmd_addr[1:0]];

  // Logic ops read the memory byte when either the source or destination is memory.
  assign src_byte = cmd_io ? io_byte : ((cmd_srcm || cmd_dstm) ? mem_byte : cmd_imm);
  assign tgt_byte = cmd_io ? io_byte : (cmd_dstm ? mem_byte : wreg_q);

  // I/O space only accepts XOR, bit clear and bit set; I/O index must exist.
  assign cmd_legal = alu_legal &&
                     (!cmd_io || ((cmd_op == SLD_OP_XOR || cmd_op == SLD_OP_BCLR || cmd_op == SLD_OP_BSET)
                                  && cmd_addr < 4'(SLD_IO_REGS)));

  assign bus_err = (paddr[1:0] != 2'b00) ||
                   !(paddr == SLD_OFF_WREG || paddr == SLD_OFF_FLAGS || paddr == SLD_OFF_CMD ||
                     in_window(paddr, SLD_OFF_MEM, SLD_MEM_WORDS) || in_window(paddr, SLD_OFF_IO, SLD_IO_REGS)) ||
                   (pwrite && paddr == SLD_OFF_CMD && !cmd_legal);

  assign acc_done = psel && penable && pready_q && !pslverr_q;
  assign op_go    = acc_done && pwrite && paddr == SLD_OFF_CMD;
  assign to_io    = cmd_io;
  assign to_mem   = !cmd_io && cmd_dstm;

  sld_alu u_alu (
    .op    (cmd_op),
    .wreg  (wreg_q),
    .src   (src_byte),
    .tgt   (tgt_byte),
    .cin   (flags_q[SLD_FLG_C]),
    .bitn  (cmd_bit),
    .res   (alu_res),
    .cout  (alu_cout),
    .upd_z (alu_upd_z),
    .upd_c (alu_upd_c),
    .legal (alu_legal)
  );

  // --------------------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------------------
  // Ready is raised at the setup edge, so every access has no wait state while
  // still coming from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && bus_err;
      if (psel && !penable && !pwrite) begin
        // A refused read must not leak a neighbour's byte through an unaligned address.
        if (bus_err) begin
          prdata_q <= 32'h0000_0000;
        end else if (paddr == SLD_OFF_WREG) begin
          prdata_q <= {24'h00_0000, wreg_q};
        end else if (paddr == SLD_OFF_FLAGS) begin
          prdata_q <= {28'h000_0000, flags_q};
        end else if (in_window(paddr, SLD_OFF_MEM, SLD_MEM_WORDS)) begin
          prdata_q <= {24'h00_0000, mem_q[word_index(paddr, SLD_OFF_MEM)]};
        end else if (in_window(paddr, SLD_OFF_IO, SLD_IO_REGS)) begin
          prdata_q <= {24'h00_0000, io_q[2'(word_index(paddr, SLD_OFF_IO))]};
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Working register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_q <= SLD_WREG_RST;
    end else if (acc_done && pwrite && paddr == SLD_OFF_WREG) begin
      wreg_q <= pwdata[7:0];
    end else if (op_go && !to_mem && !to_io) begin
      wreg_q <= alu_res;
    end
  end

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  // Half and signed-range flags are only ever changed by software here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= SLD_FLAGS_RST;
    end else if (acc_done && pwrite && paddr == SLD_OFF_FLAGS) begin
      flags_q <= pwdata[3:0];
    end else if (op_go) begin
      if (alu_upd_c) begin
        flags_q[SLD_FLG_C] <= alu_cout;
      end
      if (alu_upd_z && !to_io) begin
        flags_q[SLD_FLG_Z] <= (alu_res == 8'h00);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Data memory and I/O registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLD_MEM_WORDS; i++) begin
        mem_q[i] <= SLD_BYTE_RST;
      end
    end else if (acc_done && pwrite && in_window(paddr, SLD_OFF_MEM, SLD_MEM_WORDS)) begin
      mem_q[word_index(paddr, SLD_OFF_MEM)] <= pwdata[7:0];
    end else if (op_go && to_mem) begin
      mem_q[cmd_addr] <= alu_res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLD_IO_REGS; i++) begin
        io_q[i] <= SLD_BYTE_RST;
      end
    end else if (acc_done && pwrite && in_window(paddr, SLD_OFF_IO, SLD_IO_REGS)) begin
      io_q[2'(word_index(paddr, SLD_OFF_IO))] <= pwdata[7:0];
    end else if (op_go && to_io) begin
      io_q[cmd_addr[1:0]] <= alu_res;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign working_register = wreg_q;
  assign io_port          = {io_q[3], io_q[2], io_q[1], io_q[0]};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic w_go;
  assign w_go = op_go && !to_mem && !to_io;

  property p_srz;
    w_go && cmd_op == SLD_OP_SRZ |=> wreg_q == {1'b0, $past(wreg_q[7:1])}
      && flags_q[SLD_FLG_C] == $past(wreg_q[0]) && flags_q[SLD_FLG_Z] == $past(flags_q[SLD_FLG_Z]);
  endproperty
  a_srz: assert property (p_srz) else $error("shift right wrong");

  property p_rrc;
    w_go && cmd_op == SLD_OP_RRC |=> wreg_q == {$past(flags_q[SLD_FLG_C]), $past(wreg_q[7:1])}
      && flags_q[SLD_FLG_C] == $past(wreg_q[0]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");

  property p_slz;
    w_go && cmd_op == SLD_OP_SLZ |=> wreg_q == {$past(wreg_q[6:0]), 1'b0}
      && flags_q[SLD_FLG_C] == $past(wreg_q[7]);
  endproperty
  a_slz: assert property (p_slz) else $error("shift left wrong");

  property p_rlc;
    w_go && cmd_op == SLD_OP_RLC |=> wreg_q == {$past(wreg_q[6:0]), $past(flags_q[SLD_FLG_C])}
      && flags_q[SLD_FLG_C] == $past(wreg_q[7]) && flags_q[3:2] == $past(flags_q[3:2]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");

  property p_mem_shift;
    op_go && to_mem && cmd_op == SLD_OP_SRZ |=> mem_q[$past(cmd_addr)] == {1'b0, $past(mem_byte[7:1])}
      && flags_q[SLD_FLG_C] == $past(mem_byte[0]) && wreg_q == $past(wreg_q);
  endproperty
  a_mem_shift: assert property (p_mem_shift) else $error("memory shift wrong");

  property p_swap;
    w_go && cmd_op == SLD_OP_SWAP |=> wreg_q == {$past(wreg_q[3:0]), $past(wreg_q[7:4])}
      && $stable(flags_q);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_xor_io;
    op_go && to_io && cmd_op == SLD_OP_XOR |=> $stable(flags_q) && $stable(wreg_q)
      && io_q[$past(cmd_addr[1:0])] == ($past(wreg_q) ^ $past(io_byte));
  endproperty
  a_xor_io: assert property (p_xor_io) else $error("io xor wrong");

  property p_neg;
    w_go && cmd_op == SLD_OP_NEG |=> wreg_q == 8'(8'h00 - $past(wreg_q))
      && flags_q[SLD_FLG_Z] == ($past(wreg_q) == 8'h00) && $stable(flags_q[3:1]);
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");

  property p_io_bit;
    op_go && to_io && cmd_op == SLD_OP_BCLR |=> io_q[$past(cmd_addr[1:0])] ==
      ($past(io_byte) & ~(8'h01 << $past(cmd_bit))) && $stable(flags_q);
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("io bit clear wrong");

  property p_mem_bit;
    op_go && to_mem && cmd_op == SLD_OP_BSET |=> mem_q[$past(cmd_addr)] ==
      ($past(mem_byte) | (8'h01 << $past(cmd_bit))) && $stable(flags_q);
  endproperty
  a_mem_bit: assert property (p_mem_bit) else $error("memory bit set wrong");

  property p_zero;
    op_go && alu_upd_z && !to_io |=>
      flags_q[SLD_FLG_Z] == (($past(to_mem) ? mem_q[$past(cmd_addr)] : wreg_q) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule // sld_datapath

// >>> sld_bus_master.sv
// Purpose: APB requester standing in for the core decoder and data memory side.
// Assumes: One transfer at a time; the slave ends each access with pready.
// Notes:   Released address and data are inverted so that a stale value is never taken for a live one.

`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Bus requester
// ----------------------------------------------------------------------------
module sld_bus_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // The request is held until pready is sampled high, however long that takes.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // sld_bus_master

// >>> tb_top.sv
// Purpose: Self-checking bench for the shift, logic and bit datapath.
// Assumes: Zero wait state APB slave; commands execute at the write edge.
// Notes:   A reference model predicts every read; a monitor compares each completed access.

`timescale 1ns/100ps

module tb_top
  import sld_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  working_register;
  logic [31:0] io_port;
  logic [32:0] exp_q[$];
  logic [32:0] mon_e;
  logic [7:0]  m_mem[16];
  logic [7:0]  m_io[4];
  logic [7:0]  m_w;
  logic [3:0]  m_f;
  int          err_total;
  int          check_count;
  integer      seed;

  sld_bus_master i_sld_bus_master (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
                                   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  sld_datapath i_sld_datapath (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                               .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                               .pready(pready), .pslverr(pslverr), .working_register(working_register),
                               .io_port(io_port));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // --------------------------------------------------------------------------
  // Checking and verdict
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) begin
        check("unexpected_access", 33'h1, 33'h0);
      end else begin
        mon_e = exp_q.pop_front();
        if (pwrite)
          check("write_error", {pslverr, 32'h0}, {mon_e[32], 32'h0});
        else
          check("read_data", {pslverr, prdata}, mon_e);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transfers and reference model
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back({e, 32'h0});
    i_sld_bus_master.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back({e, d});
    i_sld_bus_master.xfer(1'b0, a, 32'h0);
  endtask

  task automatic exec(input logic [31:0] c, output logic e);
    logic [3:0] op;
    logic [3:0] ix;
    logic [7:0] t;
    logic [7:0] s;
    logic [7:0] r;
    logic       co;
    op = c[3:0];
    ix = c[15:12];
    e  = (op > 4'hb) || (c[6] && (ix > 4'h3 || !(op == SLD_OP_XOR || op == SLD_OP_BCLR || op == SLD_OP_BSET)));
    if (e)
      return;
    t  = c[6] ? m_io[ix[1:0]] : (c[4] ? m_mem[ix] : m_w);
    s  = (c[4] || c[5]) ? m_mem[ix] : c[23:16];
    co = m_f[SLD_FLG_C];
    r  = t;
    case (op)
      SLD_OP_SRZ: begin r = {1'b0, t[7:1]}; co = t[0]; end
      SLD_OP_RRC: begin r = {m_f[SLD_FLG_C], t[7:1]}; co = t[0]; end
      SLD_OP_SLZ: begin r = {t[6:0], 1'b0}; co = t[7]; end
      SLD_OP_RLC: begin r = {t[6:0], m_f[SLD_FLG_C]}; co = t[7]; end
      SLD_OP_SWAP: r = {t[3:0], t[7:4]};
      SLD_OP_AND: r = m_w & s;
      SLD_OP_OR:  r = m_w | s;
      SLD_OP_XOR: r = c[6] ? (m_w ^ t) : (m_w ^ s);
      SLD_OP_NOT: r = ~t;
      SLD_OP_NEG: r = 8'h00 - t;
      SLD_OP_BCLR: r[c[10:8]] = 1'b0;
      SLD_OP_BSET: r[c[10:8]] = 1'b1;
      default: r = t;
    endcase
    if (op <= SLD_OP_RLC)
      m_f[SLD_FLG_C] = co;
    if (op >= SLD_OP_AND && op <= SLD_OP_NEG && !c[6])
      m_f[SLD_FLG_Z] = (r == 8'h00);
    if (c[6])
      m_io[ix[1:0]] = r;
    else if (c[4])
      m_mem[ix] = r;
    else
      m_w = r;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [31:0] c;
    logic [31:0] v;
    logic        e;
    err_total   = 0;
    check_count = 0;
    seed        = 75232;
    presetn     = 1'b0;
    m_w         = 8'h00;
    m_f         = 4'h0;
    foreach (m_mem[k]) m_mem[k] = 8'h00;
    foreach (m_io[k]) m_io[k] = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(SLD_OFF_WREG, 32'h0, 1'b0);
    rd(SLD_OFF_FLAGS, 32'h0, 1'b0);
    rd(SLD_OFF_CMD, 32'h0, 1'b0);
    for (int k = 0; k < 4; k++) rd(SLD_OFF_IO + {4'h0, k[1:0], 2'b00}, 32'h0, 1'b0);
    // Unmapped and unaligned places answer with an error and read as zero.
    rd(8'h30, 32'h0, 1'b1);
    rd(8'h41, 32'h0, 1'b1);
    wr(8'h30, 32'h5a, 1'b1);
    for (int i = 0; i < 192; i++) begin
      v = $random(seed);
      if (i % 4 == 0) begin
        m_w = v[7:0];
        m_f = v[11:8];
        m_mem[v[15:12]] = v[23:16];
        m_io[v[25:24]] = v[31:24];
        wr(SLD_OFF_WREG, {24'h0, m_w}, 1'b0);
        wr(SLD_OFF_FLAGS, {28'h0, m_f}, 1'b0);
        wr(SLD_OFF_MEM + {2'b00, v[15:12], 2'b00}, {24'h0, v[23:16]}, 1'b0);
        wr(SLD_OFF_IO + {4'h0, v[25:24], 2'b00}, {24'h0, v[31:24]}, 1'b0);
      end
      c      = $random(seed);
      c[3:0] = i[3:0];
      c[6]   = c[6] & c[7];
      exec(c, e);
      wr(SLD_OFF_CMD, c, e);
      rd(SLD_OFF_WREG, {24'h0, m_w}, 1'b0);
      rd(SLD_OFF_FLAGS, {28'h0, m_f}, 1'b0);
      rd(SLD_OFF_MEM + {2'b00, c[15:12], 2'b00}, {24'h0, m_mem[c[15:12]]}, 1'b0);
      @(negedge pclk);
      check("working_register", {25'h0, working_register}, {25'h0, m_w});
      check("io_port", {1'b0, io_port}, {1'b0, m_io[3], m_io[2], m_io[1], m_io[0]});
    end
    repeat (4) @(posedge pclk);
    check("queue_left", {1'b0, 32'(exp_q.size())}, 33'h0);
    conclude();
  end

  // The run needs about 30 us; four times that leaves ample margin.
  initial begin
    #120000;
    err_total++;
    conclude();
  end
endmodule // tb_top
